//--- design/sfcr_pin_sync.sv
// Purpose: two-flop synchronisers with edge detection for link pins
// Assumes: pins are asynchronous to clock
// Notes:   the first flop feeds only the second
`timescale 1ns/1ps
module sfcr_pin_sync #(
  parameter int           W    = 3,
  parameter logic [W-1:0] IDLE = '1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // raw pins
  input  wire logic [W-1:0] pin,
  // synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_r;  // first stage
  logic [W-1:0] sync_r;  // second stage
  logic [W-1:0] prev_r;  // delayed for edges

  // ***************************************
  // synchroniser chain, preset to the idle level of each pin
  // ***************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= IDLE;
      sync_r <= IDLE;
      prev_r <= IDLE;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges from the second and third stage only
  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;

endmodule

//--- design/sfcr_regs.sv
// Purpose: configuration/status register commands of a serial flash
// Assumes: serial mode 0, link pins sampled by the 25 MHz clock
// Notes:   array program/erase lives elsewhere; busy comes in
//
// Summary of operation
// - config read accepted even while busy
// - config byte shifted out, IO1-IO3 ignored
// - config byte fields, all reset zero
// - pin function hold/reset only when quad off
// - two-bit drive strength selection
// - protect scheme selects block or lock bits
// - dummy select sets dummy clock counts
// - dummy and pattern bits volatile, zero default
// - learning pattern enable drives fixed pattern
// - register writes need write enable latch or volatile arm
// - status write keeps read-only and latch bits
// - status write ends at 8 or 16
// - one-byte status write keeps upper byte
// - valid end starts timed busy cycle
// - status readable during busy cycle
// - hardware protected mode refuses status writes
// - status write opcodes 01H and 31H
// - config write ends exactly after one byte
// - config write runs timed busy cycle
// - status bit0 busy, bit1 latch
// - volatile enable makes next write volatile
// - quad enable turns pins into data
`timescale 1ns/1ps
module sfcr_regs #(
  parameter int TW_CYCLES = sfcr_pkg::REGISTER_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // serial link pins
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   si,
  input  wire logic                   wp_n,
  output logic                        so,
  output logic                        so_oe,
  // array engine, same clock
  input  wire logic                   array_busy,
  input  wire logic                   suspend_flag,
  input  wire logic                   program_fail_flag,
  // register contents and decode
  output logic [15:0]                 status_out,
  output logic [7:0]                  config_out,
  output sfcr_pkg::sfcr_cfg_out_t     cfg_dec
);

  // ***************************************
  // pin synchronisation
  // ***************************************
  logic [2:0] pin_lvl;  // sclk, cs_n, si levels
  logic [2:0] pin_rise; // rising edges
  logic [2:0] pin_fall; // falling edges

  sfcr_pin_sync #(
    .W    (3),
    .IDLE (3'b010) // sclk low, cs_n high, si low: no false edge after reset
  ) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin     ({sclk, cs_n, si}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  logic wp_meta_r; // protect pin first stage
  logic wp_s_r;    // protect pin synchronised

  // protect pin synchroniser
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_meta_r <= 1'b1;
      wp_s_r    <= 1'b1;
    end
    else
    begin
      wp_meta_r <= wp_n;
      wp_s_r    <= wp_meta_r;
    end
  end

  logic cs_s;      // chip select level
  logic si_s;      // serial in level
  logic sclk_rise; // sample edge
  logic sclk_fall; // shift-out edge
  logic cs_rise;   // frame end
  logic cs_fall;   // frame start

  assign cs_s      = pin_lvl[1];
  assign si_s      = pin_lvl[0];
  assign sclk_rise = pin_rise[2];
  assign sclk_fall = pin_fall[2];
  assign cs_rise   = pin_rise[1];
  assign cs_fall   = pin_fall[1];

  // ***************************************
  // state and decode helpers
  // ***************************************
  sfcr_pkg::sfcr_state_t s_r;   // registered state
  sfcr_pkg::sfcr_state_t s_nxt; // next state

  logic        busy_any;   // any self-timed work running
  logic        qe;         // quad enable
  logic        hw_locked;  // status and config frozen
  logic        write_ok;   // a register write may proceed
  logic        volatile_w; // this write updates volatile copy only
  logic [15:0] status_rd;  // status as read by the host
  logic [7:0]  cfg_rd;     // config as read by the host
  logic        wr_sr_lo;   // 01H with one byte
  logic        wr_sr_both; // 01H with two bytes
  logic        wr_sr_hi;   // 31H with one byte
  logic        wr_cr;      // 11H with one byte
  logic        accept_nv;  // write starting a timed cycle
  logic [7:0]  cmd_byte;   // command as it completes
  localparam int BCW = sfcr_pkg::BUSY_CNT_W; // busy counter width

  // busy covers array work and register cycles
  assign busy_any = s_r.wr_busy | array_busy;
  assign qe       = s_r.status[sfcr_pkg::ST_QE];

  // protect pin is data while quad is on
  always_comb
  begin
    hw_locked = s_r.status[sfcr_pkg::ST_LOCK_HI] |
                (s_r.status[sfcr_pkg::ST_LOCK_LO] & ~wp_s_r & ~qe);
  end

  // status as seen by reads
  always_comb
  begin
    status_rd = {suspend_flag, s_r.status[14:11], program_fail_flag,
                 s_r.status[9:2], s_r.write_enable_latch, busy_any};
  end

  // reserved config bits never stored
  assign cfg_rd = s_r.cfg & sfcr_pkg::CFG_WRITE_MASK;

  // write frames ended exactly on a byte boundary
  always_comb
  begin
    wr_sr_lo   = (s_r.cmd == sfcr_pkg::CMD_WRITE_STATUS) &&
                 (s_r.bit_cnt == sfcr_pkg::BITS_ONE_BYTE);
    wr_sr_both = (s_r.cmd == sfcr_pkg::CMD_WRITE_STATUS) &&
                 (s_r.bit_cnt == sfcr_pkg::BITS_TWO_BYTE);
    wr_sr_hi   = (s_r.cmd == sfcr_pkg::CMD_WRITE_STATUS_HI) &&
                 (s_r.bit_cnt == sfcr_pkg::BITS_ONE_BYTE);
    wr_cr      = (s_r.cmd == sfcr_pkg::CMD_WRITE_CONFIG) &&
                 (s_r.bit_cnt == sfcr_pkg::BITS_ONE_BYTE);
  end

  // latch or volatile arm, not busy, not locked
  assign write_ok   = (s_r.write_enable_latch | s_r.vol_armed) & ~busy_any & ~hw_locked;
  assign volatile_w = s_r.vol_armed;
  assign accept_nv  = cs_rise && (s_r.phase != sfcr_pkg::PH_IDLE) && write_ok && !volatile_w &&
                      (wr_sr_lo || wr_sr_both || wr_sr_hi || wr_cr);
  assign cmd_byte   = {s_r.shift_in[6:0], si_s};

  // ***************************************
  // next-state logic
  // ***************************************
  always_comb
  begin
    s_nxt = s_r;
    // self-timed register cycle countdown
    if (s_r.wr_busy)
    begin
      if (s_r.busy_cnt == '0)
      begin
        s_nxt.wr_busy = 1'b0;
        s_nxt.write_enable_latch     = 1'b0;
      end
      else
      begin
        s_nxt.busy_cnt = s_r.busy_cnt - 1'b1;
      end
    end
    if (cs_fall)
    begin
      // new frame
      s_nxt.phase   = sfcr_pkg::PH_CMD;
      s_nxt.bit_cnt = '0;
      s_nxt.so_oe   = 1'b0;
    end
    else if (cs_rise)
    begin
      // frame end: act only on clean boundaries
      s_nxt.phase = sfcr_pkg::PH_IDLE;
      s_nxt.so_oe = 1'b0;
      if (s_r.phase != sfcr_pkg::PH_IDLE)
      begin
        // volatile arm lasts exactly one frame
        s_nxt.vol_armed = (s_r.cmd == sfcr_pkg::CMD_VOLATILE_UNLOCK) &&
                          (s_r.bit_cnt == sfcr_pkg::BITS_CMD);
        if (s_r.bit_cnt == sfcr_pkg::BITS_CMD)
        begin
          if (s_r.cmd == sfcr_pkg::CMD_WRITE_UNLOCK && !busy_any)
          begin
            s_nxt.write_enable_latch = 1'b1;
          end
          else if (s_r.cmd == sfcr_pkg::CMD_WRITE_LOCK && !s_r.wr_busy)
          begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end
        if (write_ok)
        begin
          if (wr_sr_lo)
          begin
            // low byte only, upper byte kept
            s_nxt.status[7:0] = (s_r.status[7:0] & ~sfcr_pkg::STATUS_WRITE_MASK[7:0]) |
                                (s_r.shift_in[7:0] & sfcr_pkg::STATUS_WRITE_MASK[7:0]);
          end
          else if (wr_sr_both)
          begin
            // first byte low, second byte high; otp bits only set
            s_nxt.status = (s_r.status & ~sfcr_pkg::STATUS_WRITE_MASK) |
                           ({s_r.shift_in[7:0], s_r.shift_in[15:8]} & sfcr_pkg::STATUS_WRITE_MASK) |
                           (s_r.status & sfcr_pkg::STATUS_OTP_MASK);
          end
          else if (wr_sr_hi)
          begin
            s_nxt.status[15:8] = (s_r.status[15:8] & ~sfcr_pkg::STATUS_WRITE_MASK[15:8]) |
                                 (s_r.shift_in[7:0] & sfcr_pkg::STATUS_WRITE_MASK[15:8]) |
                                 (s_r.status[15:8] & sfcr_pkg::STATUS_OTP_MASK[15:8]);
          end
          else if (wr_cr)
          begin
            s_nxt.cfg = s_r.shift_in[7:0] & sfcr_pkg::CFG_WRITE_MASK;
          end
          if (accept_nv)
          begin
            // non-volatile write: timed cycle with busy set
            s_nxt.wr_busy  = 1'b1;
            s_nxt.busy_cnt = BCW'(TW_CYCLES - 1);
          end
        end
      end
    end
    else if (!cs_s && sclk_rise)
    begin
      // sample serial input
      s_nxt.shift_in = {s_r.shift_in[14:0], si_s};
      if (s_r.bit_cnt != sfcr_pkg::BITS_MAX)
      begin
        s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
      end
      if (s_r.phase == sfcr_pkg::PH_CMD && s_r.bit_cnt == 6'h07)
      begin
        s_nxt.cmd = cmd_byte;
        unique case (cmd_byte)
          sfcr_pkg::CMD_READ_CONFIG:
          begin
            // accepted even while busy
            s_nxt.phase     = sfcr_pkg::PH_READ;
            s_nxt.shift_out = cfg_rd;
          end
          sfcr_pkg::CMD_READ_STATUS_LO:
          begin
            s_nxt.phase     = sfcr_pkg::PH_READ;
            s_nxt.shift_out = status_rd[7:0];
          end
          sfcr_pkg::CMD_READ_STATUS_HI:
          begin
            s_nxt.phase     = sfcr_pkg::PH_READ;
            s_nxt.shift_out = status_rd[15:8];
          end
          sfcr_pkg::CMD_WRITE_STATUS,
          sfcr_pkg::CMD_WRITE_STATUS_HI,
          sfcr_pkg::CMD_WRITE_CONFIG:
          begin
            s_nxt.phase = sfcr_pkg::PH_DATA;
          end
          default:
          begin
            // other commands handled elsewhere or at frame end
            s_nxt.phase = sfcr_pkg::PH_IGNORE;
          end
        endcase
      end
    end
    else if (!cs_s && sclk_fall && s_r.phase == sfcr_pkg::PH_READ)
    begin
      // shift out msb first; byte repeats until frame end
      s_nxt.so        = s_r.shift_out[7];
      s_nxt.so_oe     = 1'b1;
      s_nxt.shift_out = {s_r.shift_out[6:0], s_r.shift_out[7]};
    end
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r           <= '0;
      s_r.phase     <= sfcr_pkg::PH_IDLE;
      s_r.status    <= sfcr_pkg::STATUS_RESET;
      s_r.cfg       <= sfcr_pkg::CFG_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  assign so         = s_r.so;
  assign so_oe      = s_r.so_oe;
  assign status_out = status_rd;
  assign config_out = cfg_rd;

  // configuration decode for pins, drivers and read engine
  always_comb
  begin
    cfg_dec.pin_is_hold     = ~qe & ~s_r.cfg[sfcr_pkg::CFG_PIN_FUNC];
    cfg_dec.pin_is_reset    = ~qe & s_r.cfg[sfcr_pkg::CFG_PIN_FUNC];
    cfg_dec.drive_strength  = {s_r.cfg[sfcr_pkg::CFG_DRV_HI], s_r.cfg[sfcr_pkg::CFG_DRV_LO]};
    cfg_dec.block_lock_mode = s_r.cfg[sfcr_pkg::CFG_WPS];
    cfg_dec.dummy_bb        = s_r.cfg[sfcr_pkg::CFG_DC] ? sfcr_pkg::DUMMY_BB_LONG : sfcr_pkg::DUMMY_BB_SHORT;
    cfg_dec.dummy_eb        = s_r.cfg[sfcr_pkg::CFG_DC] ? sfcr_pkg::DUMMY_EB_LONG : sfcr_pkg::DUMMY_EB_SHORT;
    cfg_dec.dummy_ed        = s_r.cfg[sfcr_pkg::CFG_DC] ? sfcr_pkg::DUMMY_ED_LONG : sfcr_pkg::DUMMY_ED_SHORT;
    cfg_dec.learn_enable    = s_r.cfg[sfcr_pkg::CFG_DLP];
    cfg_dec.learn_pattern   = s_r.cfg[sfcr_pkg::CFG_DLP] ? sfcr_pkg::LEARN_PATTERN : 8'h00;
  end

  // ***************************************
  // assertions
  // ***************************************
  property p_cfg_read_load;
    @(posedge clock) disable iff (!reset_n)
    (!cs_s && sclk_rise && !cs_rise && !cs_fall && s_r.phase == sfcr_pkg::PH_CMD &&
     s_r.bit_cnt == 6'h07 && cmd_byte == sfcr_pkg::CMD_READ_CONFIG)
    |=> (s_r.phase == sfcr_pkg::PH_READ) && (s_r.shift_out == $past(cfg_rd));
  endproperty
  a_cfg_read_load: assert property (p_cfg_read_load) else $error("config read not loaded");

  property p_reserved_zero;
    @(posedge clock) disable iff (!reset_n)
    cs_rise |=> (s_r.cfg[4:3] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved config bits set");

  property p_no_latch_no_write;
    @(posedge clock) disable iff (!reset_n)
    (cs_rise && !s_r.write_enable_latch && !s_r.vol_armed) |=> $stable(s_r.cfg) && $stable(s_r.status) && !s_r.wr_busy;
  endproperty
  a_no_latch_no_write: assert property (p_no_latch_no_write) else $error("write without latch");

  property p_lock_refuses;
    @(posedge clock) disable iff (!reset_n)
    (cs_rise && hw_locked) |=> $stable(s_r.status) && $stable(s_r.cfg);
  endproperty
  a_lock_refuses: assert property (p_lock_refuses) else $error("write while protected");

  property p_upper_kept;
    @(posedge clock) disable iff (!reset_n)
    (cs_rise && wr_sr_lo && s_r.phase != sfcr_pkg::PH_IDLE) |=> $stable(s_r.status[15:8]);
  endproperty
  a_upper_kept: assert property (p_upper_kept) else $error("upper status changed");

  property p_busy_start;
    @(posedge clock) disable iff (!reset_n)
    accept_nv |=> s_r.wr_busy && status_out[0] ##1 s_r.busy_cnt == BCW'(TW_CYCLES - 2);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("timed cycle not started");

  property p_cycle_end;
    @(posedge clock) disable iff (!reset_n)
    (s_r.wr_busy && s_r.busy_cnt == '0) |=> !s_r.wr_busy && !s_r.write_enable_latch;
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("latch not cleared at cycle end");

  property p_bad_boundary;
    @(posedge clock) disable iff (!reset_n)
    (cs_rise && s_r.cmd == sfcr_pkg::CMD_WRITE_STATUS && s_r.bit_cnt != sfcr_pkg::BITS_ONE_BYTE &&
     s_r.bit_cnt != sfcr_pkg::BITS_TWO_BYTE) |=> $stable(s_r.status) && !$rose(s_r.wr_busy);
  endproperty
  a_bad_boundary: assert property (p_bad_boundary) else $error("misaligned status write taken");

  property p_ro_bits_kept;
    @(posedge clock) disable iff (!reset_n)
    cs_rise |=> s_r.status[1:0] == $past(s_r.status[1:0]) && s_r.status[15] == $past(s_r.status[15]);
  endproperty
  a_ro_bits_kept: assert property (p_ro_bits_kept) else $error("read-only status bits written");

  property p_oe_off;
    @(posedge clock) disable iff (!reset_n)
    cs_rise |=> !so_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven after frame");

  c_config_write: cover property (@(posedge clock) disable iff (!reset_n) accept_nv && wr_cr);
  c_status_two:   cover property (@(posedge clock) disable iff (!reset_n) accept_nv && wr_sr_both);
  c_volatile:     cover property (@(posedge clock) disable iff (!reset_n) cs_rise && write_ok && volatile_w);
  c_read_busy:    cover property (@(posedge clock) disable iff (!reset_n)
                                  s_r.wr_busy && s_r.phase == sfcr_pkg::PH_READ);

endmodule

//--- dv/sfcr_host_model.sv
// Purpose: serial host model that frames commands to the register block
// Assumes: mode 0, link clock 320 ns, steps taken on falling system clock
// Notes:   link clock stands low between frames
`timescale 1ns/1ps
module sfcr_host_model (
  // system clock for pacing
  input  wire logic clock,
  // read side
  input  wire logic so,
  input  wire logic so_oe,
  // link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  // idle link: deselected, clock low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // one half link period, 4 system clocks
  task automatic half;
    repeat (4) @(negedge clock);
  endtask

  // msb-first frame of n bits, byte after opcode captured
  task automatic xfer(input logic [23:0] tx, input int n, output logic [7:0] rx);
    int i;
    rx   = 8'h00;
    cs_n = 1'b0;
    for (i = 0; i < n; i++)
    begin
      si = tx[23-i];
      half;
      sclk = 1'b1;
      half;
      // sample just before the shifting edge
      if (i >= 8 && i < 16)
        rx = {rx[6:0], so_oe ? so : 1'bx};
      sclk = 1'b0;
    end
    half;
    cs_n = 1'b1;
    si   = ~si;
    repeat (2) half;
  endtask
endmodule

//--- dv/sfcr_regs_tb.sv
// Purpose: self-checking bench of the config/status register block
// Assumes: short register write time of 20 clocks
// Notes:   array busy input is used to hold the busy flag for reads
`timescale 1ns/1ps
module sfcr_regs_tb;
  logic                    clock, reset_n, wp_n, array_busy, suspend_flag, program_fail_flag;
  logic                    sclk, cs_n, si, so, so_oe;
  logic [15:0]             status_out;
  logic [7:0]              config_out, rx;
  sfcr_pkg::sfcr_cfg_out_t cfg_dec;
  int                      err_count, n_compared;
  int                      cycles = 0;

  sfcr_regs #(.TW_CYCLES(20)) sfcr_regs_inst (.clock(clock), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .array_busy(array_busy),
    .suspend_flag(suspend_flag), .program_fail_flag(program_fail_flag),
    .status_out(status_out), .config_out(config_out), .cfg_dec(cfg_dec));
  sfcr_host_model sfcr_host_model_inst (.clock(clock), .so(so), .so_oe(so_oe), .sclk(sclk),
    .cs_n(cs_n), .si(si));

  // 25 MHz clock
  always #20 clock = ~clock;

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic frame(input logic [23:0] d, input int n);
    sfcr_host_model_inst.xfer(d, n, rx);
  endtask

  // unlock then write
  task automatic wr(input logic [23:0] d, input int n);
    frame(24'h060000, 8);
    frame(d, n);
  endtask

  // bounded wait for busy to drop
  task automatic settle;
    int k;
    for (k = 0; k < 200 && status_out[0] !== 1'b0; k++)
      @(negedge clock);
  endtask

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      give_verdict;
    end
  end

  // main sequence
  initial
  begin
    clock = 0; reset_n = 0; wp_n = 1; array_busy = 0; suspend_flag = 0; program_fail_flag = 0;
    err_count = 0; n_compared = 0;
    repeat (2) @(negedge clock);
    reset_n = 1;
    repeat (3) @(negedge clock);
    check(config_out, 16'h0000);
    check(status_out, 16'h0000);
    frame(24'h11ff00, 16);
    settle;
    check(config_out, 16'h0000);
    frame(24'h060000, 8);
    check(status_out[1:0], 16'h0002);
    frame(24'h11ff00, 16);
    check(status_out[1:0], 16'h0003);
    check(config_out, 16'h00e7);
    settle;
    check(status_out[1:0], 16'h0000);
    check({cfg_dec.pin_is_hold, cfg_dec.pin_is_reset, cfg_dec.drive_strength}, 16'h0007);
    check(cfg_dec.block_lock_mode, 16'h0001);
    check({cfg_dec.dummy_bb, cfg_dec.dummy_eb, cfg_dec.dummy_ed}, 16'h08aa);
    check({cfg_dec.learn_enable, cfg_dec.learn_pattern}, 16'h0134);
    array_busy = 1;
    frame(24'h150000, 16);
    check(rx, 16'h00e7);
    frame(24'h050000, 16);
    check(rx, 16'h0001);
    array_busy = 0;
    frame(24'h500000, 8);
    frame(24'h11e400, 16);
    check(status_out[1:0], 16'h0000);
    check({cfg_dec.dummy_bb, cfg_dec.dummy_eb, cfg_dec.dummy_ed, config_out[7:4]}, 16'h468e);
    check({cfg_dec.learn_enable, cfg_dec.learn_pattern}, 16'h0000);
    wr(24'h110300, 12);
    settle;
    check(config_out, 16'h00e4);
    wr(24'h01fc00, 16);
    settle;
    check(status_out, 16'h00fc);
    wp_n = 0;
    wr(24'h010000, 16);
    settle;
    check(status_out, 16'h00fe);
    wp_n = 1;
    wr(24'h010000, 12);
    settle;
    check(status_out, 16'h00fe);
    wr(24'h010086, 24);
    settle;
    check(status_out, 16'h0200);
    check({cfg_dec.pin_is_hold, cfg_dec.pin_is_reset}, 16'h0000);
    wr(24'h314000, 16);
    settle;
    check(status_out, 16'h4000);
    frame(24'h350000, 16);
    check(rx, 16'h0040);
    wr(24'h011c00, 16);
    settle;
    check(status_out, 16'h401c);
    suspend_flag = 1;
    program_fail_flag = 1;
    @(negedge clock);
    check(status_out, 16'hc41c);
    frame(24'h060000, 8);
    check(status_out[1:0], 16'h0002);
    frame(24'h040000, 8);
    check(status_out[1:0], 16'h0000);
    give_verdict;
  end
endmodule

//--- inc/sfcr_pkg.sv
// Purpose: shared constants and types of the config/status register logic
// Assumes: 25 MHz system clock, serial link sampled by that clock
// Notes:   command codes and field positions live here, except the status busy, latch, fail and suspend bits
package sfcr_pkg;

  // ***************************************
  // command codes
  // ***************************************
  localparam logic [7:0] CMD_WRITE_UNLOCK    = 8'h06;
  localparam logic [7:0] CMD_WRITE_LOCK      = 8'h04;
  localparam logic [7:0] CMD_VOLATILE_UNLOCK = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS_LO  = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_HI  = 8'h35;
  localparam logic [7:0] CMD_READ_CONFIG     = 8'h15;
  localparam logic [7:0] CMD_WRITE_STATUS    = 8'h01;
  localparam logic [7:0] CMD_WRITE_STATUS_HI = 8'h31;
  localparam logic [7:0] CMD_WRITE_CONFIG    = 8'h11;

  // ***************************************
  // configuration byte layout
  // ***************************************
  localparam int         CFG_PIN_FUNC   = 7;
  localparam int         CFG_DRV_HI     = 6;
  localparam int         CFG_DRV_LO     = 5;
  localparam int         CFG_WPS        = 2;
  localparam int         CFG_DC         = 1;
  localparam int         CFG_DLP        = 0;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'he7;
  localparam logic [7:0] CFG_VOL_MASK   = 8'h03;

  // ***************************************
  // status register layout
  // ***************************************
  localparam int          ST_LOCK_LO        = 7;
  localparam int          ST_LOCK_HI        = 8;
  localparam int          ST_QE             = 9;
  localparam logic [15:0] STATUS_RESET      = 16'h0000;
  localparam logic [15:0] STATUS_WRITE_MASK = 16'h7bfc;
  localparam logic [15:0] STATUS_OTP_MASK   = 16'h3800;

  // ***************************************
  // frame lengths in serial clocks
  // ***************************************
  localparam logic [5:0] BITS_CMD      = 6'h08;
  localparam logic [5:0] BITS_ONE_BYTE = 6'h10;
  localparam logic [5:0] BITS_TWO_BYTE = 6'h18;
  localparam logic [5:0] BITS_MAX      = 6'h3f;

  // ***************************************
  // dummy counts and learning pattern
  // ***************************************
  localparam logic [3:0] DUMMY_BB_SHORT = 4'h4;
  localparam logic [3:0] DUMMY_BB_LONG  = 4'h8;
  localparam logic [3:0] DUMMY_EB_SHORT = 4'h6;
  localparam logic [3:0] DUMMY_EB_LONG  = 4'ha;
  localparam logic [3:0] DUMMY_ED_SHORT = 4'h8;
  localparam logic [3:0] DUMMY_ED_LONG  = 4'ha;
  localparam logic [7:0] LEARN_PATTERN  = 8'h34;

  // ***************************************
  // timing
  // ***************************************
  localparam int CLOCK_PERIOD_NS         = 40;
  localparam int REGISTER_WRITE_TIME_US  = 5000;
  localparam int REGISTER_WRITE_CYCLES   = (REGISTER_WRITE_TIME_US * 1000) / CLOCK_PERIOD_NS;
  localparam int BUSY_CNT_W              = 24;

  // ***************************************
  // types
  // ***************************************
  typedef enum logic [4:0] {
    PH_IDLE   = 5'b00001,
    PH_CMD    = 5'b00010,
    PH_DATA   = 5'b00100,
    PH_READ   = 5'b01000,
    PH_IGNORE = 5'b10000
  } sfcr_phase_t;

  // decoded configuration seen by the rest of the device
  typedef struct packed {
    logic       pin_is_hold;
    logic       pin_is_reset;
    logic [1:0] drive_strength;
    logic       block_lock_mode;
    logic [3:0] dummy_bb;
    logic [3:0] dummy_eb;
    logic [3:0] dummy_ed;
    logic       learn_enable;
    logic [7:0] learn_pattern;
  } sfcr_cfg_out_t;

  // state of the register block, apart from the pin synchroniser flops
  typedef struct packed {
    sfcr_phase_t           phase;
    logic [5:0]            bit_cnt;
    logic [7:0]            cmd;
    logic [15:0]           shift_in;
    logic [7:0]            shift_out;
    logic [15:0]           status;
    logic [7:0]            cfg;
    logic                  write_enable_latch;
    logic                  vol_armed;
    logic                  wr_busy;
    logic [BUSY_CNT_W-1:0] busy_cnt;
    logic                  so;
    logic                  so_oe;
  } sfcr_state_t;

endpackage
